// [pcg_pkg.sv]
// Constants shared by the programmable CRC generator
`default_nettype none
package pcg_pkg;
    // ========================================
    // Widths
    localparam int DATA_W   = 16;
    localparam int ADDR_W   = 2;
    localparam int LEN_W    = 4;
    localparam int CNT_W    = 5;
    localparam int PTR_W    = 4;
    localparam int MEM_DEPTH = 16;

    // ========================================
    // Register offsets (word index on the register port)
    localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h0;
    localparam logic [ADDR_W-1:0] OFF_TAPS    = 2'h1;
    localparam logic [ADDR_W-1:0] OFF_DATA    = 2'h2;
    localparam logic [ADDR_W-1:0] OFF_SEED    = 2'h3;

    // ========================================
    // Control register field positions
    localparam int CON_IDLE_BIT  = 13;
    localparam int CON_CNT_LSB   = 8;
    localparam int CON_FULL_BIT  = 7;
    localparam int CON_EMPTY_BIT = 6;
    localparam int CON_GO_BIT    = 4;
    localparam int CON_LEN_LSB   = 0;
    localparam int BYTE_W        = 8;
    localparam int LANE_LO       = 0;
    localparam int LANE_HI       = 1;

    // ========================================
    // Reset values and FIFO depths
    localparam logic [DATA_W-1:0] TAPS_RST  = 16'h0000;
    localparam logic [DATA_W-1:0] TAPS_MASK = 16'hFFFE;
    localparam logic [DATA_W-1:0] SEED_RST  = 16'h0000;
    localparam logic [LEN_W-1:0]  LEN_RST   = 4'h0;
    localparam logic [LEN_W-1:0]  LEN_NARROW_MAX = 4'h7;
    localparam logic [CNT_W-1:0]  DEPTH_WIDE   = 5'h08;
    localparam logic [CNT_W-1:0]  DEPTH_NARROW = 5'h10;
    localparam logic [CNT_W-1:0]  CNT_ONE      = 5'h01;
    localparam logic [CNT_W-1:0]  CNT_ZERO     = 5'h00;
endpackage
`default_nettype wire

// [pcg_fifo_mem.sv]
// Word storage for the CRC data FIFO
`default_nettype none
module pcg_fifo_mem #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int PTR_W = 4
) (
    input  wire logic             i_sys_clk,
    input  wire logic             i_wr_en,
    input  wire logic [PTR_W-1:0] i_wr_ptr,
    input  wire logic [WIDTH-1:0] i_wr_data,
    input  wire logic [PTR_W-1:0] i_rd_ptr,
    output logic      [WIDTH-1:0] o_rd_data
);
    // ========================================
    // Storage, no reset needed: the count guards every read
    logic [WIDTH-1:0] mem_q [DEPTH];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_wr_en)
        begin
            mem_q[i_wr_ptr] <= i_wr_data;
        end
    end

    assign o_rd_data = mem_q[i_rd_ptr];
endmodule
`default_nettype wire

// [pcg_lfsr.sv]
// Programmable feedback shift engine, one data bit per clock
`default_nettype none
module pcg_lfsr #(
    parameter int WIDTH  = 16,
    parameter int LEN_W  = 4
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_reset,
    input  wire logic              i_shift,
    input  wire logic              i_din,
    input  wire logic [WIDTH-1:0]  i_taps,
    input  wire logic [LEN_W-1:0]  i_poly_len,
    input  wire logic              i_load,
    input  wire logic [WIDTH-1:0]  i_load_val,
    output logic      [WIDTH-1:0]  o_crc
);
    // ========================================
    // Next state
    logic [WIDTH-1:0] crc_q;
    logic [WIDTH-1:0] crc_d;
    logic             fb;

    always_comb
    begin
        fb    = i_din ^ crc_q[i_poly_len];
        crc_d = '0;
        crc_d[0] = fb;
        for (int i = 1; i < WIDTH; i++)
        begin
            // Top term x^(plen+1) is implied by the feedback itself
            if (i <= int'(i_poly_len))
            begin
                crc_d[i] = crc_q[i-1] ^ (fb & i_taps[i]);
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            crc_q <= '0;
        end
        else if (i_load)
        begin
            crc_q <= i_load_val;
        end
        else if (i_shift)
        begin
            crc_q <= crc_d;
        end
    end

    assign o_crc = crc_q;
endmodule
`default_nettype wire

// [pcg_top.sv]
// Programmable CRC generator with data FIFO and register port
// Notes on behaviour
// - Tap positions come from tap register, length from four-bit length field.
// - The x^0 term and the top term are always applied.
// - Shifting never starts before software sets the shift-go bit.
// - FIFO holds 8 words when length exceeds 7, else 16.
// - Data writes are byte granular; a word has length plus one bits.
// - Count rises when the byte holding the word's top bit is written.
// - Shifter pops words while shift-go is set or it is still busy draining, and count is nonzero.
// - Count falls when a word's top bit leaves; run until count zero.
// - One bit per clock, length plus one cycles per word.
// - Full flag set when count equals FIFO depth.
// - Empty flag set when count is zero.
// - Writing while full wraps the count to zero without interrupt.
// - Interrupt fires when the count goes from one to zero.
// - Sleep freezes all shifting state until clocks return.
// - Idle with idle-halt set freezes like sleep; no pops, so no new interrupts, while frozen.
// - Clearing shift-go stops the shifter only once the FIFO is empty.
// - Count is a five-bit read-only field in the control register.
`default_nettype none
module pcg_top (
    input  wire logic                         i_sys_clk,
    input  wire logic                         i_reset,
    input  wire logic [pcg_pkg::ADDR_W-1:0]   i_reg_addr,
    input  wire logic [pcg_pkg::DATA_W-1:0]   i_reg_wdata,
    input  wire logic [1:0]                   i_reg_be,
    input  wire logic                         i_reg_wr,
    input  wire logic                         i_reg_rd,
    input  wire logic                         i_sleep,
    input  wire logic                         i_idle,
    output logic      [pcg_pkg::DATA_W-1:0]   o_reg_rdata,
    output logic                              o_irq
);
    // ========================================
    // Software registers
    logic [pcg_pkg::DATA_W-1:0] poly_taps_reg_q;
    logic [pcg_pkg::LEN_W-1:0]  poly_len_field_q;
    logic                       shift_go_q;
    logic                       idle_halt_q;
    logic [7:0]                 stage_lo_q;

    logic wr_con;
    logic wr_taps;
    logic wr_data;
    logic wr_seed;
    logic freeze;

    assign wr_con  = i_reg_wr && (i_reg_addr == pcg_pkg::OFF_CONTROL);
    assign wr_taps = i_reg_wr && (i_reg_addr == pcg_pkg::OFF_TAPS);
    assign wr_data = i_reg_wr && (i_reg_addr == pcg_pkg::OFF_DATA);
    assign wr_seed = i_reg_wr && (i_reg_addr == pcg_pkg::OFF_SEED);

    // Idle only halts when software asked for it
    assign freeze = i_sleep || (i_idle && idle_halt_q);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            poly_len_field_q <= pcg_pkg::LEN_RST;
            shift_go_q       <= 1'b0;
            idle_halt_q      <= 1'b0;
        end
        else if (wr_con)
        begin
            if (i_reg_be[pcg_pkg::LANE_LO])
            begin
                poly_len_field_q <= i_reg_wdata[pcg_pkg::CON_LEN_LSB +: pcg_pkg::LEN_W];
                shift_go_q       <= i_reg_wdata[pcg_pkg::CON_GO_BIT];
            end
            if (i_reg_be[pcg_pkg::LANE_HI])
            begin
                idle_halt_q <= i_reg_wdata[pcg_pkg::CON_IDLE_BIT];
            end
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            poly_taps_reg_q <= pcg_pkg::TAPS_RST;
        end
        else if (wr_taps)
        begin
            for (int b = 0; b < 2; b++)
            begin
                if (i_reg_be[b])
                begin
                    poly_taps_reg_q[b*pcg_pkg::BYTE_W +: pcg_pkg::BYTE_W] <=
                        i_reg_wdata[b*pcg_pkg::BYTE_W +: pcg_pkg::BYTE_W]
                        & pcg_pkg::TAPS_MASK[b*pcg_pkg::BYTE_W +: pcg_pkg::BYTE_W];
                end
            end
        end
    end

    // ========================================
    // Data word assembly
    logic                       wide;
    logic                       push_req;
    logic [pcg_pkg::DATA_W-1:0] push_word;

    assign wide = poly_len_field_q > pcg_pkg::LEN_NARROW_MAX;

    // A word counts only once the byte with its top bit arrives
    assign push_req = wr_data && (wide ? i_reg_be[pcg_pkg::LANE_HI]
                                       : i_reg_be[pcg_pkg::LANE_LO]);

    always_comb
    begin
        push_word = '0;
        if (wide)
        begin
            push_word[15:8] = i_reg_wdata[15:8];
            push_word[7:0]  = i_reg_be[pcg_pkg::LANE_LO] ? i_reg_wdata[7:0] : stage_lo_q;
        end
        else
        begin
            push_word[7:0] = i_reg_wdata[7:0];
        end
    end

    // Low byte of a wide word may come first on its own
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            stage_lo_q <= 8'h00;
        end
        else if (wr_data && i_reg_be[pcg_pkg::LANE_LO])
        begin
            stage_lo_q <= i_reg_wdata[7:0];
        end
    end

    // ========================================
    // FIFO pointers and valid-word count
    logic [pcg_pkg::CNT_W-1:0]  fifo_valid_count_q;
    logic [pcg_pkg::PTR_W-1:0]  wr_ptr_q;
    logic [pcg_pkg::PTR_W-1:0]  rd_ptr_q;
    logic [pcg_pkg::CNT_W-1:0]  depth;
    logic                       fifo_full_flag;
    logic                       fifo_empty_flag;
    logic                       wrap;
    logic                       push;
    logic                       pop;
    logic [pcg_pkg::DATA_W-1:0] head_word;

    assign depth = wide ? pcg_pkg::DEPTH_WIDE : pcg_pkg::DEPTH_NARROW;
    assign fifo_full_flag  = fifo_valid_count_q == depth;
    assign fifo_empty_flag = fifo_valid_count_q == pcg_pkg::CNT_ZERO;
    assign wrap = push_req && fifo_full_flag;
    assign push = push_req && !fifo_full_flag;

    pcg_fifo_mem #(
        .WIDTH (pcg_pkg::DATA_W),
        .DEPTH (pcg_pkg::MEM_DEPTH),
        .PTR_W (pcg_pkg::PTR_W)
    ) u_mem (
        .i_sys_clk (i_sys_clk),
        .i_wr_en   (push),
        .i_wr_ptr  (wr_ptr_q),
        .i_wr_data (push_word),
        .i_rd_ptr  (rd_ptr_q),
        .o_rd_data (head_word)
    );

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            fifo_valid_count_q <= pcg_pkg::CNT_ZERO;
            wr_ptr_q           <= '0;
            rd_ptr_q           <= '0;
        end
        else if (wrap)
        begin
            // Overrun discards everything queued, the word written included
            fifo_valid_count_q <= pcg_pkg::CNT_ZERO;
            rd_ptr_q           <= wr_ptr_q;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop)
            begin
                fifo_valid_count_q <= fifo_valid_count_q + 1'b1;
            end
            else if (pop && !push)
            begin
                fifo_valid_count_q <= fifo_valid_count_q - 1'b1;
            end
        end
    end

    // ========================================
    // Serial shifter
    logic [pcg_pkg::DATA_W-1:0] shift_word_q;
    logic [pcg_pkg::LEN_W-1:0]  bits_left_q;
    logic                       busy_q;
    logic                       running;
    logic                       in_word;
    logic                       shift;
    logic                       din;
    logic [pcg_pkg::DATA_W-1:0] crc;

    // Keeps draining after go is cleared until the queue is empty
    assign running = shift_go_q || busy_q;
    assign in_word = bits_left_q != '0;
    assign pop     = !freeze && !wrap && running && !in_word
                     && !fifo_empty_flag;
    assign shift   = pop || (!freeze && in_word);
    assign din     = pop ? head_word[poly_len_field_q]
                         : shift_word_q[bits_left_q - 1'b1];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            busy_q       <= 1'b0;
            bits_left_q  <= '0;
            shift_word_q <= '0;
        end
        else if (!freeze)
        begin
            if (pop)
            begin
                shift_word_q <= head_word;
                bits_left_q  <= poly_len_field_q;
                busy_q       <= 1'b1;
            end
            else if (in_word)
            begin
                bits_left_q <= bits_left_q - 1'b1;
            end
            else if (fifo_empty_flag)
            begin
                busy_q <= 1'b0;
            end
        end
    end

    pcg_lfsr #(
        .WIDTH  (pcg_pkg::DATA_W),
        .LEN_W  (pcg_pkg::LEN_W)
    ) u_lfsr (
        .i_sys_clk  (i_sys_clk),
        .i_reset    (i_reset),
        .i_shift    (shift),
        .i_din      (din),
        .i_taps     (poly_taps_reg_q),
        .i_poly_len (poly_len_field_q),
        .i_load     (wr_seed),
        .i_load_val (i_reg_wdata),
        .o_crc      (crc)
    );

    // ========================================
    // Interrupt: not gated by freeze so pending events still pass
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_irq <= 1'b0;
        end
        else
        begin
            o_irq <= pop && !push
                     && (fifo_valid_count_q == pcg_pkg::CNT_ONE);
        end
    end

    // ========================================
    // Read port, data valid only in the cycle after the strobe
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            o_reg_rdata <= '0;
        end
        else
        begin
            o_reg_rdata <= '0;
            if (i_reg_rd)
            begin
                case (i_reg_addr)
                    pcg_pkg::OFF_CONTROL:
                    begin
                        o_reg_rdata[pcg_pkg::CON_IDLE_BIT] <= idle_halt_q;
                        o_reg_rdata[pcg_pkg::CON_CNT_LSB +: pcg_pkg::CNT_W]
                            <= fifo_valid_count_q;
                        o_reg_rdata[pcg_pkg::CON_FULL_BIT]  <= fifo_full_flag;
                        o_reg_rdata[pcg_pkg::CON_EMPTY_BIT] <= fifo_empty_flag;
                        o_reg_rdata[pcg_pkg::CON_GO_BIT]    <= shift_go_q;
                        o_reg_rdata[pcg_pkg::CON_LEN_LSB +: pcg_pkg::LEN_W]
                            <= poly_len_field_q;
                    end
                    pcg_pkg::OFF_TAPS: o_reg_rdata <= poly_taps_reg_q;
                    pcg_pkg::OFF_DATA: o_reg_rdata <= crc;
                    pcg_pkg::OFF_SEED: o_reg_rdata <= crc;
                    default:           o_reg_rdata <= '0;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// [pcg_top_sva.sv]
// Port-level assertion checker for the programmable CRC generator
`default_nettype none
module pcg_top_sva (
    input wire logic        i_sys_clk,
    input wire logic        i_reset,
    input wire logic [1:0]  i_reg_addr,
    input wire logic [15:0] i_reg_wdata,
    input wire logic [1:0]  i_reg_be,
    input wire logic        i_reg_wr,
    input wire logic        i_reg_rd,
    input wire logic        i_sleep,
    input wire logic        i_idle,
    input wire logic [15:0] o_reg_rdata,
    input wire logic        o_irq
);
    // ========================================
    // Shadow of the writable control bits
    logic [3:0] len_q;
    logic       go_q;
    logic       ever_q;
    logic       halt_q;
    logic       ctl_wr;
    assign ctl_wr = i_reg_wr && (i_reg_addr == pcg_pkg::OFF_CONTROL);

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            len_q  <= 4'h0;
            go_q   <= 1'b0;
            ever_q <= 1'b0;
        end
        else if (ctl_wr && i_reg_be[0])
        begin
            len_q  <= i_reg_wdata[3:0];
            go_q   <= i_reg_wdata[4];
            ever_q <= ever_q | i_reg_wdata[4];
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
            halt_q <= 1'b0;
        else if (ctl_wr && i_reg_be[1])
            halt_q <= i_reg_wdata[13];
    end

    // ========================================
    // Assertions
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_reset);
    sequence s_ctl;
        i_reg_rd && (i_reg_addr == pcg_pkg::OFF_CONTROL);
    endsequence
    sequence s_tap;
        i_reg_rd && (i_reg_addr == pcg_pkg::OFF_TAPS);
    endsequence

    AST_RDATA_IDLE: assert property (!i_reg_rd |=> o_reg_rdata == 16'h0000)
        else $error("read data not zero outside read cycle");
    AST_CTL_RSVD: assert property (s_ctl |=>
        o_reg_rdata[15:14] == 2'h0 && !o_reg_rdata[5])
        else $error("unused control bits read nonzero");
    AST_EMPTY_FLAG: assert property (s_ctl |=>
        o_reg_rdata[6] == (o_reg_rdata[12:8] == 5'h00))
        else $error("empty flag disagrees with count");
    AST_FULL_FLAG: assert property (s_ctl |=>
        o_reg_rdata[7] == (o_reg_rdata[12:8] ==
        ((o_reg_rdata[3:0] > 4'h7) ? pcg_pkg::DEPTH_WIDE : pcg_pkg::DEPTH_NARROW)))
        else $error("full flag disagrees with count");
    AST_DEPTH: assert property (s_ctl |=>
        o_reg_rdata[12:8] <=
        ((o_reg_rdata[3:0] > 4'h7) ? pcg_pkg::DEPTH_WIDE : pcg_pkg::DEPTH_NARROW))
        else $error("count above fifo depth");
    AST_CTL_FIELDS: assert property (s_ctl |=>
        o_reg_rdata[4] == go_q && o_reg_rdata[3:0] == len_q && o_reg_rdata[13] == halt_q)
        else $error("control fields differ from last write");
    AST_TAPS_B0: assert property (s_tap |=> !o_reg_rdata[0])
        else $error("tap bit zero reads one");
    AST_NO_GO: assert property (!ever_q |-> !o_irq)
        else $error("interrupt before shifting was started");
    AST_SLEEP: assert property ($past(i_sleep) |-> !o_irq)
        else $error("interrupt from a pop while asleep");
    AST_IDLE: assert property ($past(i_idle && halt_q) |-> !o_irq)
        else $error("interrupt from a pop while halted in idle");
endmodule

bind pcg_top pcg_top_sva u_pcg_sva (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_be(i_reg_be), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .i_sleep(i_sleep), .i_idle(i_idle),
    .o_reg_rdata(o_reg_rdata), .o_irq(o_irq)
);
`default_nettype wire

// [test_programmable_crc_generator.sv]
// Self-checking testbench for the programmable CRC generator
`default_nettype none
module test_programmable_crc_generator;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0]  len;
        logic [15:0] taps;
        logic [15:0] word;
        logic [4:0]  depth;
    } pcg_row_t;
    logic        i_sys_clk, i_reset, i_reg_wr, i_reg_rd, i_sleep, i_idle, o_irq, seen;
    logic [1:0]  i_reg_addr, i_reg_be;
    logic [15:0] i_reg_wdata, o_reg_rdata, d, crc;
    int          failures, checked, n;
    // Tap bit zero set on the 8-, 9- and 16-bit rows: it must be ignored
    pcg_row_t    rows [5] = '{'{4'h7, 16'h00A7, 16'h005A, 5'h10},
        '{4'h8, 16'h0131, 16'h01C3, 5'h08}, '{4'hF, 16'h1021, 16'hBEEF, 5'h08},
        '{4'h0, 16'h0000, 16'h0001, 5'h10}, '{4'h3, 16'h000E, 16'h0009, 5'h10}};

    pcg_top dut (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_reg_be(i_reg_be), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_sleep(i_sleep), .i_idle(i_idle),
        .o_reg_rdata(o_reg_rdata), .o_irq(o_irq));

    initial
    begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end

    // ========================================
    // Bus and check helpers
    task automatic check(input string name, input logic [15:0] sv, input logic [15:0] ev);
        checked++;
        if (sv !== ev)
        begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, ev, sv);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [15:0] v, input logic [1:0] be);
        i_reg_addr  <= a;
        i_reg_wdata <= v;
        i_reg_be    <= be;
        i_reg_wr    <= 1'b1;
        i_reg_rd    <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    // Data is taken before the edge's updates land, so no race with the design
    task automatic rd(input logic [1:0] a);
        i_reg_addr <= a;
        i_reg_wr   <= 1'b0;
        i_reg_rd   <= 1'b1;
        @(posedge i_sys_clk);
        i_reg_rd <= 1'b0;
        @(posedge i_sys_clk);
        d = o_reg_rdata;
    endtask
    task automatic idle(input int k);
        i_reg_wr <= 1'b0;
        i_reg_rd <= 1'b0;
        repeat (k) @(posedge i_sys_clk);
    endtask
    task automatic push(input logic [15:0] w, input logic [3:0] p);
        if (p > 4'h7)
            wr(pcg_pkg::OFF_DATA, w, 2'b11);
        else
            wr(pcg_pkg::OFF_DATA, w, 2'b01);
    endtask
    // A wait that must see the pulse ends the run when its bound runs out
    task automatic wait_irq(input int lim, input bit must);
        idle(0);
        n = 0;
        seen = 1'b0;
        while (!seen && n < lim)
        begin
            @(posedge i_sys_clk);
            n++;
            seen = (o_irq === 1'b1);
        end
        if (must && !seen)
        begin
            check("irq_wait", 16'h0000, 16'h0001);
            give_verdict;
        end
    endtask
    task automatic do_reset;
        i_reset <= 1'b1;
        idle(10);
        i_reset <= 1'b0;
    endtask
    // MSb first; feedback is data bit xor top bit, into bit 0 and each enabled tap
    function automatic logic [15:0] model(logic [15:0] c, logic [15:0] w, logic [15:0] t,
                                          logic [3:0] p);
        logic [15:0] nx;
        logic        fb;
        for (int b = int'(p); b >= 0; b--)
        begin
            fb = w[b] ^ c[p];
            nx = 16'h0000;
            nx[0] = fb;
            for (int i = 1; i <= int'(p); i++)
                nx[i] = c[i-1] ^ (fb & t[i]);
            c = nx;
        end
        return c;
    endfunction
    task automatic give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ========================================
    // Main sequence
    initial
    begin
        {i_reset, i_reg_wr, i_reg_rd, i_sleep, i_idle} = 5'h10;
        {i_reg_addr, i_reg_be, i_reg_wdata} = 20'h00000;
        failures = 0;
        checked = 0;
        do_reset;
        foreach (rows[r])
        begin
            crc = 16'h0000;
            wr(pcg_pkg::OFF_SEED, crc, 2'b11);
            wr(pcg_pkg::OFF_TAPS, rows[r].taps, 2'b11);
            wr(pcg_pkg::OFF_CONTROL, {12'h000, rows[r].len}, 2'b11);
            for (int k = 0; k < int'(rows[r].depth); k++)
            begin
                d = (rows[r].word + 16'(k * 309)) & (16'hFFFF >> (4'hF - rows[r].len));
                push(d, rows[r].len);
                crc = model(crc, d, rows[r].taps, rows[r].len);
            end
            rd(pcg_pkg::OFF_CONTROL);
            check("count", {11'h000, d[12:8]}, {11'h000, rows[r].depth});
            check("full_empty", {14'h0000, d[7:6]}, 16'h0002);
            wr(pcg_pkg::OFF_CONTROL, {12'h001, rows[r].len}, 2'b11);
            wait_irq(400, 1'b1);
            check("irq_delay", 16'(n), 16'((int'(rows[r].depth) - 1) *
                (int'(rows[r].len) + 1) + 2));
            idle(int'(rows[r].len) + 1);
            rd(pcg_pkg::OFF_CONTROL);
            check("drained", {9'h000, d[12:6]}, 16'h0001);
            rd(pcg_pkg::OFF_DATA);
            check("crc", d, crc);
            rd(pcg_pkg::OFF_TAPS);
            check("taps", d, rows[r].taps & pcg_pkg::TAPS_MASK);
        end
        wr(pcg_pkg::OFF_CONTROL, 16'h0003, 2'b11);
        wr(pcg_pkg::OFF_SEED, 16'h0005, 2'b11);
        repeat (17) push(16'h0009, 4'h3);
        rd(pcg_pkg::OFF_CONTROL);
        check("wrap", {9'h000, d[12:6]}, 16'h0001);
        wr(pcg_pkg::OFF_CONTROL, 16'h0013, 2'b11);
        wait_irq(40, 1'b0);
        check("wrap_irq", {15'h0000, seen}, 16'h0000);
        i_sleep <= 1'b1;
        push(16'h000B, 4'h3);
        idle(6);
        rd(pcg_pkg::OFF_CONTROL);
        check("sleep_hold", {11'h000, d[12:8]}, 16'h0001);
        i_sleep <= 1'b0;
        wait_irq(20, 1'b1);
        check("sleep_resume", 16'(n), 16'h0002);
        idle(4);
        rd(pcg_pkg::OFF_DATA);
        check("sleep_crc", d, model(16'h0005, 16'h000B, 16'h000E, 4'h3));
        wr(pcg_pkg::OFF_CONTROL, 16'h2013, 2'b11);
        i_idle <= 1'b1;
        push(16'h0006, 4'h3);
        idle(6);
        rd(pcg_pkg::OFF_CONTROL);
        check("halt_hold", {11'h000, d[12:8]}, 16'h0001);
        wr(pcg_pkg::OFF_CONTROL, 16'h0013, 2'b11);
        wait_irq(20, 1'b1);
        check("idle_run", 16'(n), 16'h0002);
        i_idle <= 1'b0;
        push(16'h0001, 4'h3);
        push(16'h0002, 4'h3);
        wr(pcg_pkg::OFF_CONTROL, 16'h0003, 2'b11);
        wait_irq(40, 1'b1);
        check("go_drain", {15'h0000, seen}, 16'h0001);
        do_reset;
        rd(pcg_pkg::OFF_CONTROL);
        check("rst_ctl", d, 16'h0040);
        rd(pcg_pkg::OFF_TAPS);
        check("rst_taps", d, pcg_pkg::TAPS_RST);
        rd(pcg_pkg::OFF_DATA);
        check("rst_crc", d, pcg_pkg::SEED_RST);
        // Wide word sent as two single-byte writes, low byte first
        wr(pcg_pkg::OFF_CONTROL, 16'h000F, 2'b11);
        wr(pcg_pkg::OFF_DATA, 16'h00C3, 2'b01);
        rd(pcg_pkg::OFF_CONTROL);
        check("lo_only", {11'h000, d[12:8]}, 16'h0000);
        wr(pcg_pkg::OFF_DATA, 16'h5A00, 2'b10);
        rd(pcg_pkg::OFF_CONTROL);
        check("hi_push", {11'h000, d[12:8]}, 16'h0001);
        wr(pcg_pkg::OFF_CONTROL, 16'h001F, 2'b11);
        wait_irq(20, 1'b1);
        idle(16);
        rd(pcg_pkg::OFF_SEED);
        check("staged_crc", d, model(16'h0000, 16'h5AC3, 16'h0000, 4'hF));
        give_verdict;
    end
endmodule
`default_nettype wire
